// ===== rtl/psc_params.svh
// Offsets, field positions, reset values and timing counts of the press supervisory control
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// =====================================================================
// Timebase
`define PSC_CLK_HZ 64'd250000000
`define PSC_SEC_S 64'd1
`define PSC_SEC_CYCLES (`PSC_SEC_S * `PSC_CLK_HZ)
`define PSC_INIT_S 64'd12
`define PSC_INIT_CYCLES (`PSC_INIT_S * `PSC_CLK_HZ)
`define PSC_HOLD_S 64'd2
`define PSC_HOLD_CYCLES (`PSC_HOLD_S * `PSC_CLK_HZ)
`define PSC_DAY_SECS 17'h1517f
`define PSC_LAST_DAY 3'h6
`define PSC_HOUR_SECS 17'd3600

// =====================================================================
// Register byte offsets
`define PSC_REG_CTRL 8'h00
`define PSC_REG_STATUS 8'h04
`define PSC_REG_TOD 8'h08
`define PSC_REG_SCHED0 8'h0c
`define PSC_REG_SCHED1 8'h10
`define PSC_REG_SPRAY 8'h14
`define PSC_REG_HOURS 8'h18
`define PSC_REG_PANEL 8'h1c

// =====================================================================
// Control register bits
`define PSC_CTRL_REGIME 0
`define PSC_CTRL_RESET 1
`define PSC_CTRL_ACLR 2
`define PSC_CTRL_KCLOSE 3

// Reset values
`define PSC_SPRAY_RST 32'h0000_0000
`define PSC_SCHED_RST 18'h0_0000

`endif

// ===== rtl/psc_pkg.sv
// Types shared by the press supervisory control
`default_nettype none
package psc_pkg;
  // Controller states
  typedef enum logic [2:0] {
    ST_INIT, ST_ESTOP, ST_IDLE, ST_MANUAL, ST_AUTO
  } psc_state_t;

  // Button colour code
  typedef enum logic [1:0] {
    COL_GREY, COL_BLUE, COL_GREEN, COL_RED
  } psc_colour_t;

  // Field interlocks and panel selector
  typedef struct packed {
    logic estop_pushed;
    logic remote_estop;
    logic hoa_hand;
    logic hoa_auto;
    logic breaker_trip;
    logic tank_high;
    logic drive_fault;
    logic water_press_ok;
    logic polymer_ok;
  } psc_intlk_t;

  // Controlled equipment
  typedef struct packed {
    logic feed_pump;
    logic flash_mixer;
    logic floc_mixer;
    logic drum;
    logic polymer_pump;
    logic spray_valve;
  } psc_dev_t;

  // One time-clock schedule
  typedef struct packed {
    logic enable;
    logic [4:0] stop_hour;
    logic [4:0] start_hour;
    logic [6:0] days;
  } psc_sched_t;
endpackage : psc_pkg
`default_nettype wire

// ===== rtl/psc_top.sv
// Press supervisory control: sequencing, interlocks, schedules, meter, Wishbone registers
//
// Behaviour
// - Power-up initialisation lasts 10-15 s, inhibiting operation.
// - Initialisation restores drives, clears faults and alarms.
// - Initialisation reruns on e-stop release or reset.
// - E-stop pushed switches every output off immediately; code clears dev_o, run light and colour slots 0-5; power light, alarm and keypad stay.
// - Selector picks Manual, Off or Auto.
// - Manual toggles devices; faults do not stop them.
// - Run-hour meter frozen in Manual mode.
// - Auto runs itself, stops on any problem.
// - Auto runs continuously or by time clock.
// - Two independent day/hour schedules, both may act.
// - Auto needs e-stops clear, Auto, no trip.
// - Auto needs tank below high, drives healthy.
// - Auto needs water above 20 psi, polymer.
// - Power-up in Auto starts press when called.
// - Running light only in Auto operating; power light.
// - Instant-change buttons act after two-second hold.
// - Manual buttons inactive, ignored while in Auto.
// - Colours: blue available, green on, red action, grey.
// - Numeric button opens keypad for value entry.
// - Zero spray off-time keeps spray on continuously.
//
// Register access over Wishbone and the address map are this design's own decisions.
`include "psc_params.svh"
`default_nettype none
module psc_top
  import psc_pkg::*;
#(
  parameter logic [31:0] SEC_CYCLES = 32'(`PSC_SEC_CYCLES),
  parameter logic [31:0] INIT_CYCLES = 32'(`PSC_INIT_CYCLES),
  parameter logic [31:0] HOLD_CYCLES = 32'(`PSC_HOLD_CYCLES)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Panel pins and field interlocks
  input wire psc_intlk_t intlk_i,
  input wire logic [5:0] man_btn_i,
  input wire logic num_btn_i,
  // Equipment and indicators
  output psc_dev_t dev_o,
  output logic drive_init_o,
  output logic run_light_o,
  output logic power_light_o,
  output logic alarm_o,
  output logic keypad_open_o,
  output psc_colour_t [6:0] colour_o
);

  // =====================================================================
  // Helpers
  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] psc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : psc_merge

  // Schedule asks for running at this day and hour
  function automatic logic psc_hit(input psc_sched_t s, input logic [2:0] day, input logic [4:0] hour);
    return s.enable && s.days[day] && (hour >= s.start_hour) && (hour < s.stop_hour);
  endfunction : psc_hit

  // =====================================================================
  // Input synchronisers
  psc_intlk_t ilk_meta_r; // First stage, read only by second
  psc_intlk_t ilk_r; // Safe interlock levels
  logic [6:0] btn_meta_r; // Button first stage
  logic [6:0] btn_r; // Button safe levels

  // Two flip-flops on every pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ilk_meta_r <= '0;
      ilk_r <= '0;
      btn_meta_r <= '0;
      btn_r <= '0;
    end else begin
      ilk_meta_r <= intlk_i;
      ilk_r <= ilk_meta_r;
      btn_meta_r <= {num_btn_i, man_btn_i};
      btn_r <= btn_meta_r;
    end
  end

  // =====================================================================
  // Wishbone register file
  logic ack_r; // Answer strobe
  logic [31:0] rdat_r; // Read data
  logic regime_r; // Zero continuous, one time clock
  psc_sched_t sched_r [2]; // Two time clocks
  logic [31:0] spray_r; // On seconds low, off seconds high
  logic wr_tod; // Software sets time of day
  logic rst_cmd; // Menu reset command
  logic aclr_cmd; // Alarm clear command
  logic kclose_cmd; // Keypad entry finished
  logic req; // New bus request
  logic [31:0] status_w; // Status word

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_tod = req && wb_we_i && (wb_adr_i == `PSC_REG_TOD);
  assign rst_cmd = req && wb_we_i && (wb_adr_i == `PSC_REG_CTRL) && wb_sel_i[0] && wb_dat_i[`PSC_CTRL_RESET];
  assign aclr_cmd = req && wb_we_i && (wb_adr_i == `PSC_REG_CTRL) && wb_sel_i[0] && wb_dat_i[`PSC_CTRL_ACLR];
  assign kclose_cmd = req && wb_we_i && (wb_adr_i == `PSC_REG_CTRL) && wb_sel_i[0] && wb_dat_i[`PSC_CTRL_KCLOSE];

  // Answer one cycle after the request is seen, drop the next cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Writable configuration
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regime_r <= 1'b0;
      sched_r[0] <= `PSC_SCHED_RST;
      sched_r[1] <= `PSC_SCHED_RST;
      spray_r <= `PSC_SPRAY_RST;
    end else if (req && wb_we_i) begin
      case (wb_adr_i)
        `PSC_REG_CTRL: begin
          if (wb_sel_i[0]) begin
            regime_r <= wb_dat_i[`PSC_CTRL_REGIME];
          end
        end
        `PSC_REG_SCHED0: sched_r[0] <= 18'(psc_merge(32'(sched_r[0]), wb_dat_i, wb_sel_i));
        `PSC_REG_SCHED1: sched_r[1] <= 18'(psc_merge(32'(sched_r[1]), wb_dat_i, wb_sel_i));
        `PSC_REG_SPRAY: spray_r <= psc_merge(spray_r, wb_dat_i, wb_sel_i);
        default: begin
          // Read-only or unmapped: write ignored
        end
      endcase
    end
  end

  // =====================================================================
  // Timebase, time of day and schedules
  logic [31:0] sec_cnt_r; // Cycle prescaler
  logic tick; // One-second strobe
  logic [16:0] tod_r; // Second of day
  logic [2:0] day_r; // Day of week
  logic call; // Run regime calls for running

  assign tick = (sec_cnt_r == SEC_CYCLES - 32'h1);

  // Second prescaler
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sec_cnt_r <= '0;
    end else begin
      sec_cnt_r <= tick ? 32'h0 : sec_cnt_r + 32'h1;
    end
  end

  // Clock of day, software set wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tod_r <= '0;
      day_r <= '0;
    end else if (wr_tod) begin
      tod_r <= wb_dat_i[16:0];
      day_r <= wb_dat_i[19:17];
    end else if (tick) begin
      if (tod_r == `PSC_DAY_SECS) begin
        tod_r <= '0;
        day_r <= (day_r == `PSC_LAST_DAY) ? 3'h0 : day_r + 3'h1;
      end else begin
        tod_r <= tod_r + 17'h1;
      end
    end
  end

  assign call = !regime_r || psc_hit(sched_r[0], day_r, 5'(tod_r / `PSC_HOUR_SECS))
                           || psc_hit(sched_r[1], day_r, 5'(tod_r / `PSC_HOUR_SECS));

  // =====================================================================
  // Permissives
  logic permit; // All Auto conditions met
  assign permit = !ilk_r.estop_pushed && !ilk_r.remote_estop && ilk_r.hoa_auto && !ilk_r.hoa_hand
                  && !ilk_r.breaker_trip && !ilk_r.tank_high && !ilk_r.drive_fault
                  && ilk_r.water_press_ok && ilk_r.polymer_ok;

  // =====================================================================
  // Sequencer
  psc_state_t state_r; // Controller state
  logic [31:0] init_cnt_r; // Initialisation timer
  logic init_done; // Timer expired

  assign init_done = (init_cnt_r == INIT_CYCLES - 32'h1);

  // Mode and sequence transitions
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_INIT;
    end else if (ilk_r.estop_pushed) begin
      state_r <= ST_ESTOP;
    end else if (rst_cmd) begin
      state_r <= ST_INIT;
    end else begin
      case (state_r)
        ST_INIT: begin
          // Hold off until the timer ends
          if (init_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_ESTOP: state_r <= ST_INIT;
        default: begin
          if (ilk_r.hoa_hand && !ilk_r.hoa_auto) begin
            state_r <= ST_MANUAL;
          end else if (ilk_r.hoa_auto && !ilk_r.hoa_hand) begin
            state_r <= ST_AUTO;
          end else begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Initialisation timer, restarts on every entry
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt_r <= '0;
    end else begin
      // Menu reset inside start-up begins the full span again
      init_cnt_r <= (state_r == ST_INIT && !init_done && !rst_cmd) ? init_cnt_r + 32'h1 : 32'h0;
    end
  end

  // =====================================================================
  // Auto running and alarm
  logic run_r; // Press running in Auto
  logic alarm_r; // Latched shutdown alarm
  logic trip; // Permissive lost while running

  assign trip = (state_r == ST_AUTO) && run_r && !permit;

  // Run whenever Auto, permitted, called and alarm free
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= (state_r == ST_AUTO) && permit && call && !alarm_r && !trip;
    end
  end

  // Latch on trip; set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_r <= 1'b0;
    end else if (trip) begin
      alarm_r <= 1'b1;
    end else if (aclr_cmd || state_r == ST_INIT) begin
      alarm_r <= 1'b0;
    end
  end

  // =====================================================================
  // Two-second hold qualification of instant buttons
  logic [31:0] hold_cnt_r; // Hold time counter
  logic [5:0] held_r; // Pattern being held
  logic fire; // Hold reached once

  assign fire = (hold_cnt_r == HOLD_CYCLES - 32'h1) && (held_r != 6'h0);

  // Count while the same pattern stays pressed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_r <= '0;
      held_r <= '0;
    end else if (btn_r[5:0] != held_r) begin
      held_r <= btn_r[5:0];
      hold_cnt_r <= '0;
    end else if (held_r != 6'h0 && hold_cnt_r != HOLD_CYCLES) begin
      hold_cnt_r <= hold_cnt_r + 32'h1;
    end
  end

  // =====================================================================
  // Manual switches
  logic [5:0] man_r; // Manual device states

  // Toggle only in Manual; cleared elsewhere
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      man_r <= '0;
    end else if (state_r != ST_MANUAL) begin
      man_r <= '0;
    end else if (fire) begin
      man_r <= man_r ^ held_r;
    end
  end

  // =====================================================================
  // Drum spray cycling
  logic [15:0] spray_cnt_r; // Seconds in phase
  logic spray_on_r; // Current spray phase

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spray_cnt_r <= '0;
      spray_on_r <= 1'b1;
    end else if (!run_r || spray_r[31:16] == 16'h0) begin
      spray_cnt_r <= '0;
      spray_on_r <= 1'b1;
    end else if (tick) begin
      if (spray_cnt_r + 16'h1 >= (spray_on_r ? spray_r[15:0] : spray_r[31:16])) begin
        spray_cnt_r <= '0;
        spray_on_r <= !spray_on_r;
      end else begin
        spray_cnt_r <= spray_cnt_r + 16'h1;
      end
    end
  end

  // =====================================================================
  // Outputs
  logic [31:0] hours_r; // Run-hour meter in seconds

  // Everything off outside Manual and Auto running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dev_o <= '0;
    end else if (ilk_r.estop_pushed) begin
      dev_o <= '0;
    end else if (state_r == ST_MANUAL) begin
      dev_o <= man_r;
    end else if (state_r == ST_AUTO && run_r) begin
      dev_o <= {5'h1f, spray_on_r};
    end else begin
      dev_o <= '0;
    end
  end

  // Meter counts Auto running seconds only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hours_r <= '0;
    end else if (tick && state_r == ST_AUTO && run_r) begin
      hours_r <= hours_r + 32'h1;
    end
  end

  // Drive link restore and fault reset during start-up
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drive_init_o <= 1'b1;
      run_light_o <= 1'b0;
      power_light_o <= 1'b1;
      alarm_o <= 1'b0;
    end else begin
      drive_init_o <= (state_r == ST_INIT);
      run_light_o <= (state_r == ST_AUTO) && run_r;
      power_light_o <= 1'b1;
      alarm_o <= alarm_r;
    end
  end

  // Numeric button opens keypad until entry done
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      keypad_open_o <= 1'b0;
    end else if (btn_r[6]) begin
      keypad_open_o <= 1'b1;
    end else if (kclose_cmd) begin
      keypad_open_o <= 1'b0;
    end
  end

  // Button colours; slot six is alarm clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      colour_o <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        colour_o[i] <= (state_r != ST_MANUAL) ? COL_GREY : (man_r[i] ? COL_GREEN : COL_BLUE);
      end
      colour_o[6] <= alarm_r ? COL_RED : COL_GREY;
    end
  end

  // =====================================================================
  // Read mux
  assign status_w = {14'h0, ilk_r, permit, alarm_r, run_r, call, 2'h0, state_r};

  // Unmapped addresses read zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdat_r <= '0;
    end else if (req) begin
      case (wb_adr_i)
        `PSC_REG_CTRL: rdat_r <= {31'h0, regime_r};
        `PSC_REG_STATUS: rdat_r <= status_w;
        `PSC_REG_TOD: rdat_r <= {12'h0, day_r, tod_r};
        `PSC_REG_SCHED0: rdat_r <= 32'(sched_r[0]);
        `PSC_REG_SCHED1: rdat_r <= 32'(sched_r[1]);
        `PSC_REG_SPRAY: rdat_r <= spray_r;
        `PSC_REG_HOURS: rdat_r <= hours_r;
        `PSC_REG_PANEL: rdat_r <= {4'h0, keypad_open_o, 7'(dev_o), 6'(man_r), 14'(colour_o)};
        default: rdat_r <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_estop_off;
    ilk_r.estop_pushed |=> dev_o == '0 && state_r == ST_ESTOP;
  endproperty
  a_estop_off: assert property (p_estop_off) else $error("e-stop left an output on");

  property p_init_inhibit;
    state_r == ST_INIT |=> dev_o == '0 && !run_r;
  endproperty
  a_init_inhibit: assert property (p_init_inhibit) else $error("operation during start-up");

  property p_init_len;
    $fell(state_r == ST_INIT) && !ilk_r.estop_pushed |-> $past(init_cnt_r) == INIT_CYCLES - 32'h1;
  endproperty
  a_init_len: assert property (p_init_len) else $error("start-up ended early");

  property p_drive_init;
    state_r == ST_INIT ##1 state_r == ST_INIT |-> drive_init_o && !alarm_r;
  endproperty
  a_drive_init: assert property (p_drive_init) else $error("drives not reset in start-up");

  property p_rerun;
    state_r == ST_ESTOP && !ilk_r.estop_pushed |=> state_r == ST_INIT ##1 drive_init_o;
  endproperty
  a_rerun: assert property (p_rerun) else $error("release did not rerun start-up");

  property p_auto_ignore;
    state_r != ST_MANUAL |=> man_r == '0;
  endproperty
  a_auto_ignore: assert property (p_auto_ignore) else $error("manual switch live outside manual");

  property p_meter_frozen;
    state_r != ST_AUTO |=> $stable(hours_r);
  endproperty
  a_meter_frozen: assert property (p_meter_frozen) else $error("meter moved outside auto");

  property p_trip_latch;
    trip |=> alarm_r && !run_r ##1 dev_o == '0;
  endproperty
  a_trip_latch: assert property (p_trip_latch) else $error("trip not latched");

  property p_run_light;
    run_light_o |-> $past(state_r == ST_AUTO && run_r);
  endproperty
  a_run_light: assert property (p_run_light) else $error("running light wrong");

  property p_spray_cont;
    run_r && state_r == ST_AUTO && spray_r[31:16] == 16'h0 && !ilk_r.estop_pushed
      ##1 run_r && state_r == ST_AUTO && !ilk_r.estop_pushed |=> dev_o.spray_valve;
  endproperty
  a_spray_cont: assert property (p_spray_cont) else $error("spray cycled at zero off-time");

  c_init_done: cover property (state_r == ST_INIT ##1 state_r == ST_IDLE);
  c_auto_run: cover property (run_light_o);
  c_trip: cover property (trip ##1 alarm_o);
  c_man_toggle: cover property (state_r == ST_MANUAL && fire);

endmodule : psc_top
`default_nettype wire

// ===== testbench/psc_panel_model.sv
// Operator panel and field interlock model for the press supervisory control
`default_nettype none
module psc_panel_model
  import psc_pkg::*;
#(
  parameter int HOLD = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Commands from the bench
  input wire logic [1:0] hoa,
  input wire psc_intlk_t upset,
  input wire logic [6:0] press,
  // Pins toward the controller
  output psc_intlk_t intlk_o,
  output logic [5:0] man_btn_o,
  output logic num_btn_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Field levels
  psc_intlk_t healthy; // All permissives good
  int cnt_r; // Remaining hold cycles
  logic [6:0] held_r; // Pattern being held
  always_comb begin
    healthy = '0;
    healthy.hoa_hand = hoa[1];
    healthy.hoa_auto = hoa[0];
    healthy.water_press_ok = 1'b1;
    healthy.polymer_ok = 1'b1;
  end
  // Upset bits flip healthy levels to fault levels
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intlk_o <= '0;
    end else begin
      intlk_o <= healthy ^ upset;
    end
  end
  // ==========================================================
  // Button press
  // held past two seconds
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 0;
      held_r <= '0;
    end else if (press != 7'h00) begin
      cnt_r <= HOLD + 6;
      held_r <= press;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end else begin
      held_r <= '0;
    end
  end
  assign man_btn_o = held_r[5:0];
  assign num_btn_o = held_r[6];
endmodule : psc_panel_model
`default_nettype wire

// ===== testbench/psc_top_tb.sv
// Self-checking bench for the press supervisory control
`default_nettype none
module psc_top_tb;
  import psc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, rd, h0;
  logic wb_ack_o, drive_init_o, run_light_o, power_light_o, alarm_o, keypad_open_o;
  logic [1:0] hoa = 2'h0;
  psc_intlk_t upset = '0;
  psc_intlk_t intlk;
  logic [6:0] press = 7'h00;
  logic [5:0] man_btn;
  logic num_btn;
  psc_dev_t dev_o;
  psc_colour_t [6:0] colour_o;
  int errors = 0;
  int check_count = 0;
  always #2 mclk = ~mclk;
  // ==========================================================
  // Design and panel
  psc_top #(.SEC_CYCLES(32'd10), .INIT_CYCLES(32'd20), .HOLD_CYCLES(32'd8)) dut (
    .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .intlk_i(intlk), .man_btn_i(man_btn), .num_btn_i(num_btn), .dev_o(dev_o),
    .drive_init_o(drive_init_o), .run_light_o(run_light_o), .power_light_o(power_light_o),
    .alarm_o(alarm_o), .keypad_open_o(keypad_open_o), .colour_o(colour_o));
  psc_panel_model #(.HOLD(8)) panel (
    .mclk(mclk), .reset_n(reset_n), .hoa(hoa), .upset(upset), .press(press),
    .intlk_o(intlk), .man_btn_o(man_btn), .num_btn_o(num_btn));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Let n edges pass, then sample settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Classic single Wishbone cycle; only the watchdog ends the wait for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  // One-cycle command to the panel
  task automatic push(input logic [6:0] p);
    @(posedge mclk);
    press <= p;
    @(posedge mclk);
    press <= 7'h00;
  endtask : push
  // Selector and field upsets change together on a rising edge
  task automatic field(input logic [1:0] h, input psc_intlk_t u);
    @(posedge mclk);
    hoa <= h;
    upset <= u;
  endtask : field
  // ==========================================================
  // Scenarios
  task automatic t_init;
    chk(drive_init_o, 1'b1);
    chk(power_light_o, 1'b1);
    tick(40);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd[2:0], 3'h2);
    chk(drive_init_o, 1'b0);
    $display("test init done");
  endtask : t_init
  task automatic t_auto;
    field(2'h1, '0);
    tick(12);
    chk(run_light_o, 1'b1);
    chk(dev_o[5:1], 5'h1f);
    chk(dev_o[0], 1'b1);
    chk(colour_o[5], COL_GREY);
    tick(40);
    wb(1'b0, 8'h18, 32'h0, rd);
    chk(rd != 32'h0, 1'b1);
    // Time clock regime with no schedule enabled stops the press
    wb(1'b1, 8'h00, 32'h1, rd);
    tick(6);
    chk(run_light_o, 1'b0);
    // Second schedule alone, all days, hours 0 to 1
    wb(1'b1, 8'h10, 32'h0002_107f, rd);
    tick(6);
    chk(run_light_o, 1'b1);
    $display("test auto done");
  endtask : t_auto
  // Losing a permissive stops and latches
  task automatic t_trip;
    field(2'h1, 9'h002);
    tick(8);
    chk(run_light_o, 1'b0);
    chk(alarm_o, 1'b1);
    chk(colour_o[6], COL_RED);
    field(2'h1, '0);
    tick(8);
    chk(run_light_o, 1'b0);
    wb(1'b1, 8'h00, 32'h4, rd);
    tick(8);
    chk({alarm_o, run_light_o}, 2'h1);
    field(2'h1, 9'h008);
    tick(8);
    chk(run_light_o, 1'b0);
    field(2'h1, '0);
    $display("test trip done");
  endtask : t_trip
  // Stop from a running press, then restart through start-up
  task automatic t_estop;
    wb(1'b1, 8'h00, 32'h4, rd);
    tick(8);
    chk(dev_o, 6'h3f);
    field(2'h1, 9'h100);
    tick(6);
    chk(dev_o, 6'h00);
    field(2'h1, '0);
    tick(6);
    chk(drive_init_o, 1'b1);
    tick(24);
    chk(run_light_o, 1'b1);
    $display("test estop done");
  endtask : t_estop
  // Manual toggle, faults ignored, meter frozen
  task automatic t_manual;
    field(2'h2, '0);
    tick(45);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd[2:0], 3'h3);
    wb(1'b0, 8'h18, 32'h0, h0);
    push(7'h20);
    tick(20);
    chk(dev_o[5], 1'b1);
    chk(colour_o[5], COL_GREEN);
    chk(colour_o[4], COL_BLUE);
    field(2'h2, 9'h008);
    tick(30);
    chk(dev_o[5], 1'b1);
    chk(run_light_o, 1'b0);
    wb(1'b0, 8'h18, 32'h0, rd);
    chk(rd, h0);
    field(2'h2, '0);
    $display("test manual done");
  endtask : t_manual
  task automatic t_misc;
    push(7'h40);
    tick(4);
    chk(keypad_open_o, 1'b1);
    tick(20);
    wb(1'b1, 8'h00, 32'h8, rd);
    tick(2);
    chk(keypad_open_o, 1'b0);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test misc done");
  endtask : t_misc
  // ==========================================================
  // Verdict
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    tick(1);
    t_init();
    t_auto();
    t_trip();
    t_estop();
    t_manual();
    t_misc();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    complete_run();
  end
endmodule : psc_top_tb
`default_nettype wire
